/* hw/vm_exit_pkg.sv */
// Constants, register map and enumerations for the exit event information recorder.
package vm_exit_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the APB slave.
    localparam logic [11:0] VEC_INFO_OFF   = 12'h000;
    localparam logic [11:0] VEC_ERR_OFF    = 12'h004;
    localparam logic [11:0] INSTR_LEN_OFF  = 12'h008;
    localparam logic [11:0] INSTR_INFO_OFF = 12'h00C;
    localparam logic [11:0] CAP_OFF        = 12'h010;
    localparam logic [11:0] CTRL_OFF       = 12'h014;
    localparam logic [11:0] STATUS_OFF     = 12'h018;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int VEC_LO      = 0;
    localparam int VEC_HI      = 7;
    localparam int TYPE_LO     = 8;
    localparam int TYPE_HI     = 10;
    localparam int ERRV_BIT    = 11;
    localparam int UNDEF_BIT   = 12;
    localparam int ZERO_LO     = 13;
    localparam int ZERO_HI     = 30;
    localparam int VALID_BIT   = 31;
    localparam int EXT_BIT     = 0;
    localparam int ADDR_LO     = 7;
    localparam int ADDR_HI     = 9;
    localparam int SEG_LO      = 15;
    localparam int SEG_HI      = 17;
    localparam int LEN_W       = 4;
    localparam int CAP_PS_BIT  = 0;
    localparam int CTRL_VME    = 0;
    localparam int CTRL_TPRSH  = 1;
    localparam int CTRL_X2V    = 2;
    localparam int ST_DURING   = 0;
    localparam int ST_LEN      = 1;
    localparam int ST_INFO     = 2;
    localparam int ST_CNT_LO   = 16;
    localparam int ST_CNT_HI   = 31;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and encodings.
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    localparam logic [2:0]  CTRL_RESET     = 3'h0;
    localparam logic [2:0]  TYPE_EXT_INTR  = 3'h0;
    localparam logic [2:0]  TYPE_NMI       = 3'h2;
    localparam logic [2:0]  TYPE_HW_EXC    = 3'h3;
    localparam logic [2:0]  TYPE_SW_INTR   = 3'h4;
    localparam logic [2:0]  TYPE_PRIV_SW   = 3'h5;
    localparam logic [2:0]  TYPE_SW_EXC    = 3'h6;
    localparam logic [7:0]  NMI_VECTOR     = 8'h02;
    localparam logic [7:0]  EXC_VEC_MASK   = 8'h1F;
    localparam logic [7:0]  BP_VECTOR      = 8'h03;
    localparam logic [7:0]  OF_VECTOR      = 8'h04;

    typedef enum logic [3:0] {
        CAUSE_BITMAP_FAULT,
        CAUSE_TASK_SWITCH,
        CAUSE_LIC_LINEAR,
        CAUSE_LIC_PHYSICAL,
        CAUSE_SLT_VIOLATION,
        CAUSE_SLT_MISCONFIG,
        CAUSE_INSTR,
        CAUSE_SW_EXCEPTION,
        CAUSE_DIRECT_EVENT,
        CAUSE_DOUBLE_FAULT,
        CAUSE_HANDLER_FETCH,
        CAUSE_TRIPLE_FAULT
    } exit_cause_t;

    typedef enum logic [2:0] {
        KIND_EXT_INTR,
        KIND_NMI,
        KIND_EXCEPTION,
        KIND_SW_INTR,
        KIND_PRIV_SW_INTR
    } ev_kind_t;

    typedef enum logic [1:0] {
        TS_CALL,
        TS_INTERRUPT_RETURN,
        TS_JMP,
        TS_GATE
    } ts_src_t;

endpackage : vm_exit_pkg

/* hw/event_type_classifier.sv */
// Combinational classification of the event being delivered into type, vector and error-code flag.
`timescale 1ns/1ps
module event_type_classifier (
    input  wire vm_exit_pkg::ev_kind_t ev_kind,
    input  wire logic [7:0]            ev_vector,
    input  wire logic                  ev_sw_instr,
    input  wire logic                  ev_has_error_code,
    input  wire logic                  ev_injected,
    output logic [2:0]                 ev_type,
    output logic [7:0]                 ev_vec_field,
    output logic                       ev_err_valid,
    output logic                       ev_is_soft
);

    always_comb begin
        ev_type      = vm_exit_pkg::TYPE_EXT_INTR;
        ev_vec_field = ev_vector;
        ev_err_valid = 1'b0;
        case (ev_kind)
            vm_exit_pkg::KIND_NMI: begin
                ev_type      = vm_exit_pkg::TYPE_NMI;
                ev_vec_field = vm_exit_pkg::NMI_VECTOR;
            end
            vm_exit_pkg::KIND_EXCEPTION: begin
                ev_vec_field = ev_vector & vm_exit_pkg::EXC_VEC_MASK;
                if (ev_sw_instr && (ev_vector == vm_exit_pkg::BP_VECTOR || ev_vector == vm_exit_pkg::OF_VECTOR)) begin
                    ev_type = vm_exit_pkg::TYPE_SW_EXC;
                end else begin
                    ev_type = vm_exit_pkg::TYPE_HW_EXC;
                    ev_err_valid = ev_has_error_code;
                end
            end
            vm_exit_pkg::KIND_SW_INTR: begin
                ev_type = vm_exit_pkg::TYPE_SW_INTR;
            end
            vm_exit_pkg::KIND_PRIV_SW_INTR: begin
                ev_type = ev_injected ? vm_exit_pkg::TYPE_PRIV_SW : vm_exit_pkg::TYPE_SW_INTR;
            end
            default: begin
                ev_type = vm_exit_pkg::TYPE_EXT_INTR;
            end
        endcase
        ev_is_soft = (ev_type == vm_exit_pkg::TYPE_SW_INTR) || (ev_type == vm_exit_pkg::TYPE_PRIV_SW)
                   || (ev_type == vm_exit_pkg::TYPE_SW_EXC);
    end

endmodule : event_type_classifier

/* hw/vm_exit_event_info_recorder.sv */
// Exit event information recorder: computes the fields on each guest exit and serves them over APB.
//
// Notes on behaviour
// - Bitmap-caused fault during table delivery counts as an exit during delivery.
// - Task-gate delivery exits count only once initial task-switch checks have passed.
// - Controller page access and translation faults during delivery count as during delivery.
// - Software interrupts via real-mode table count when v86 flag and extensions set.
// - Events injected at guest entry use the delivery fields like guest events.
// - Direct causes, double fault, handler fetch and triple fault are never during delivery.
// - Bits 7:0 hold exception vector up to 31, 2 for NMI, or interrupt number.
// - Bits 10:8 hold the event type code of the event being delivered.
// - Breakpoint and overflow traps are software exceptions; all others hardware.
// - Privileged software interrupt type appears only for events injected at entry.
// - Bit 11 set for hardware exceptions pushing an error code; code recorded.
// - Valid field: bit 12 undefined, bits 30:13 zero, bit 31 one.
// - Exits not during delivery clear bit 31 of the vectoring field.
// - Error code field holds the code with external-origin flag when valid.
// - Length recorded for fault-like intercepts, not for shadowed trap-like writes.
// - Length recorded for software exception exits and bitmap or linear controller faults during soft delivery.
// - Length recorded for instruction task switches once initial checks pass, and for gates during soft delivery.
// - Recorded length is the byte length of the instruction, 1 to 15.
// - Injected original events copy the entry instruction length instead.
// - Length undefined for every other exit, including physical controller accesses.
// - Instruction information filled for the listed instructions by their layout.
// - Port-string exits put the address size code in bits 9:7.
// - Port-string output exits put the segment code in bits 17:15.
// - Capability register reports support for the port-string information layout.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module vm_exit_event_info_recorder #(
    parameter logic PORT_STRING_LAYOUT = 1'b1
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [31:0]                   prdata_q,
    output logic                          pready_q,
    output logic                          pslverr_q,
    input  wire logic                     exit_strobe,
    input  wire vm_exit_pkg::exit_cause_t exit_cause,
    input  wire logic                     delivery_active,
    input  wire logic                     delivery_via_idt,
    input  wire logic                     delivery_via_rm_table,
    input  wire logic                     v86_mode_flag,
    input  wire logic                     task_checks_passed,
    input  wire vm_exit_pkg::ts_src_t     task_switch_source,
    input  wire vm_exit_pkg::ev_kind_t    ev_kind,
    input  wire logic [7:0]               ev_vector,
    input  wire logic                     ev_sw_instr,
    input  wire logic                     ev_has_error_code,
    input  wire logic [31:0]              ev_error_code,
    input  wire logic                     external_origin_flag,
    input  wire logic                     ev_injected,
    input  wire logic [3:0]               entry_instr_length,
    input  wire logic [3:0]               instr_length,
    input  wire logic                     instr_trap_like,
    input  wire logic                     instr_task_priority_write,
    input  wire logic                     instr_model_register_write,
    input  wire logic                     instr_port_string,
    input  wire logic                     instr_port_string_output,
    input  wire logic [1:0]               instr_addr_size,
    input  wire logic [2:0]               instr_segment,
    output logic                          exit_recorded_q,
    output logic                          vectoring_valid_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Event classification.
    logic [2:0] ev_type;
    logic [7:0] ev_vec_field;
    logic       ev_err_valid;
    logic       ev_is_soft;

    event_type_classifier u_classifier (
        .ev_kind           (ev_kind),
        .ev_vector         (ev_vector),
        .ev_sw_instr       (ev_sw_instr),
        .ev_has_error_code (ev_has_error_code),
        .ev_injected       (ev_injected),
        .ev_type           (ev_type),
        .ev_vec_field      (ev_vec_field),
        .ev_err_valid      (ev_err_valid),
        .ev_is_soft        (ev_is_soft)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control state written by software.
    logic [2:0]  ctrl_q;
    logic        vme_en;
    logic        tpr_shadow_en;
    logic        x2apic_virt_en;

    assign vme_en         = ctrl_q[vm_exit_pkg::CTRL_VME];
    assign tpr_shadow_en  = ctrl_q[vm_exit_pkg::CTRL_TPRSH];
    assign x2apic_virt_en = ctrl_q[vm_exit_pkg::CTRL_X2V];

    ////////////////////////////////////////////////////////////////////////////
    // Exit classification.
    logic path_ok;
    logic during_d;
    logic len_valid_d;
    logic use_entry_len;
    logic info_valid_d;
    logic shadowed_trap;

    always_comb begin
        path_ok = delivery_via_idt
                || (delivery_via_rm_table && v86_mode_flag && vme_en && ev_kind == vm_exit_pkg::KIND_SW_INTR);
        during_d = 1'b0;
        if (delivery_active && path_ok) begin
            case (exit_cause)
                vm_exit_pkg::CAUSE_BITMAP_FAULT: begin
                    during_d = 1'b1;
                end
                vm_exit_pkg::CAUSE_TASK_SWITCH: begin
                    during_d = task_checks_passed && task_switch_source == vm_exit_pkg::TS_GATE;
                end
                vm_exit_pkg::CAUSE_LIC_LINEAR, vm_exit_pkg::CAUSE_LIC_PHYSICAL,
                vm_exit_pkg::CAUSE_SLT_VIOLATION, vm_exit_pkg::CAUSE_SLT_MISCONFIG: begin
                    during_d = 1'b1;
                end
                default: begin
                    during_d = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        shadowed_trap = instr_trap_like
                     && ((instr_task_priority_write && tpr_shadow_en) || (instr_model_register_write && x2apic_virt_en));
        len_valid_d   = 1'b0;
        use_entry_len = 1'b0;
        case (exit_cause)
            vm_exit_pkg::CAUSE_INSTR: begin
                len_valid_d = !instr_trap_like && !shadowed_trap;
            end
            vm_exit_pkg::CAUSE_SW_EXCEPTION: begin
                len_valid_d = 1'b1;
            end
            vm_exit_pkg::CAUSE_BITMAP_FAULT, vm_exit_pkg::CAUSE_LIC_LINEAR: begin
                len_valid_d   = during_d && ev_is_soft;
                use_entry_len = ev_injected;
            end
            vm_exit_pkg::CAUSE_TASK_SWITCH: begin
                if (task_switch_source == vm_exit_pkg::TS_GATE) begin
                    len_valid_d   = during_d && ev_is_soft;
                    use_entry_len = ev_injected;
                end else begin
                    len_valid_d = task_checks_passed;
                end
            end
            default: begin
                len_valid_d = 1'b0;
            end
        endcase
        info_valid_d = exit_cause == vm_exit_pkg::CAUSE_INSTR && instr_port_string && PORT_STRING_LAYOUT;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field assembly.
    logic [31:0] vec_info_d;
    logic [31:0] vec_err_d;
    logic [31:0] instr_info_d;
    logic [3:0]  len_d;

    always_comb begin
        vec_info_d   = vm_exit_pkg::REG_RESET;
        vec_err_d    = vm_exit_pkg::REG_RESET;
        instr_info_d = vm_exit_pkg::REG_RESET;
        len_d        = 4'h0;
        if (during_d) begin
            vec_info_d[vm_exit_pkg::VEC_HI:vm_exit_pkg::VEC_LO] = ev_vec_field;
            vec_info_d[vm_exit_pkg::TYPE_HI:vm_exit_pkg::TYPE_LO] = ev_type;
            vec_info_d[vm_exit_pkg::ERRV_BIT] = ev_err_valid;
            vec_info_d[vm_exit_pkg::VALID_BIT] = 1'b1;
            if (ev_err_valid) begin
                vec_err_d                       = ev_error_code;
                vec_err_d[vm_exit_pkg::EXT_BIT] = external_origin_flag;
            end
        end
        vec_info_d[vm_exit_pkg::UNDEF_BIT] = 1'b0;
        vec_info_d[vm_exit_pkg::ZERO_HI:vm_exit_pkg::ZERO_LO] = 18'h0;
        if (len_valid_d) begin
            len_d = use_entry_len ? entry_instr_length : instr_length;
        end
        if (info_valid_d) begin
            instr_info_d[vm_exit_pkg::ADDR_HI:vm_exit_pkg::ADDR_LO] = {1'b0, instr_addr_size};
            if (instr_port_string_output) begin
                instr_info_d[vm_exit_pkg::SEG_HI:vm_exit_pkg::SEG_LO] = instr_segment;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Recorded fields, captured on the exit strobe.
    logic [31:0] vec_info_q;
    logic [31:0] vec_err_q;
    logic [31:0] instr_info_q;
    logic [3:0]  len_q;
    logic [2:0]  status_flags_q;
    logic [15:0] exit_count_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_info_q     <= vm_exit_pkg::REG_RESET;
            vec_err_q      <= vm_exit_pkg::REG_RESET;
            instr_info_q   <= vm_exit_pkg::REG_RESET;
            len_q          <= 4'h0;
            status_flags_q <= 3'h0;
        end else if (exit_strobe) begin
            vec_info_q     <= vec_info_d;
            vec_err_q      <= vec_err_d;
            instr_info_q   <= instr_info_d;
            len_q          <= len_d;
            status_flags_q <= {info_valid_d, len_valid_d, during_d};
        end
    end

    // The count wraps silently; software is expected to read it as a change indicator only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exit_count_q <= 16'h0000;
        end else if (exit_strobe) begin
            exit_count_q <= exit_count_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exit_recorded_q   <= 1'b0;
            vectoring_valid_q <= 1'b0;
        end else begin
            exit_recorded_q <= exit_strobe;
            if (exit_strobe) begin
                vectoring_valid_q <= during_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave with one wait state; writes land at the edge that samples pready high.
    logic        access;
    logic        write_now;
    logic [31:0] rd_data;
    logic        rd_err;
    logic [31:0] cap_word;
    logic [31:0] status_word;

    assign access    = psel && penable && !pready_q;
    assign write_now = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb begin
        cap_word = vm_exit_pkg::REG_RESET;
        cap_word[vm_exit_pkg::CAP_PS_BIT] = PORT_STRING_LAYOUT;
        status_word = vm_exit_pkg::REG_RESET;
        status_word[vm_exit_pkg::ST_INFO:vm_exit_pkg::ST_DURING] = status_flags_q;
        status_word[vm_exit_pkg::ST_CNT_HI:vm_exit_pkg::ST_CNT_LO] = exit_count_q;
        rd_err  = 1'b0;
        rd_data = vm_exit_pkg::REG_RESET;
        if (paddr == vm_exit_pkg::VEC_INFO_OFF) begin
            rd_data = vec_info_q;
        end else if (paddr == vm_exit_pkg::VEC_ERR_OFF) begin
            rd_data = vec_err_q;
        end else if (paddr == vm_exit_pkg::INSTR_LEN_OFF) begin
            rd_data = {28'h0, len_q};
        end else if (paddr == vm_exit_pkg::INSTR_INFO_OFF) begin
            rd_data = instr_info_q;
        end else if (paddr == vm_exit_pkg::CAP_OFF) begin
            rd_data = cap_word;
        end else if (paddr == vm_exit_pkg::CTRL_OFF) begin
            rd_data = {29'h0, ctrl_q};
        end else if (paddr == vm_exit_pkg::STATUS_OFF) begin
            rd_data = status_word;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= vm_exit_pkg::REG_RESET;
        end else if (access) begin
            pready_q  <= 1'b1;
            pslverr_q <= rd_err;
            prdata_q  <= (pwrite || rd_err) ? vm_exit_pkg::REG_RESET : rd_data;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= vm_exit_pkg::REG_RESET;
        end
    end

    // Only the control register is writable; writes elsewhere in the map are ignored without error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= vm_exit_pkg::CTRL_RESET;
        end else if (write_now && paddr == vm_exit_pkg::CTRL_OFF && pstrb[0]) begin
            ctrl_q <= pwdata[2:0];
        end
    end

endmodule : vm_exit_event_info_recorder

/* dv/vm_exit_sva.sv */
// Concurrent checks on the ports of the exit event information recorder.
`timescale 1ns/1ps
module vm_exit_sva (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pready_q,
    input wire logic                     exit_strobe,
    input wire vm_exit_pkg::exit_cause_t exit_cause,
    input wire logic                     delivery_active,
    input wire logic                     delivery_via_idt,
    input wire logic                     task_checks_passed,
    input wire vm_exit_pkg::ts_src_t     task_switch_source,
    input wire logic                     exit_recorded_q,
    input wire logic                     vectoring_valid_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The three checks that predict the vectoring field on table delivery share this qualifier, so a flipped path condition trips several of them.
    wire logic on_idt = exit_strobe && delivery_active && delivery_via_idt;
    a_apb_one_wait: assert property (psel && penable && !pready_q |=> pready_q)
        else $error("no answer after one wait state");
    a_ready_pulse: assert property (pready_q |=> !pready_q)
        else $error("ready held too long");
    a_exit_pulse: assert property (exit_strobe |=> exit_recorded_q)
        else $error("exit not recorded");
    a_bitmap_during: assert property (
        on_idt && exit_cause == vm_exit_pkg::CAUSE_BITMAP_FAULT |=> vectoring_valid_q) else $error("fault not valid");
    a_gate_checked: assert property (
        on_idt && exit_cause == vm_exit_pkg::CAUSE_TASK_SWITCH && task_switch_source == vm_exit_pkg::TS_GATE
        |=> vectoring_valid_q == $past(task_checks_passed)) else $error("gate validity wrong");
    a_slt_during: assert property (
        on_idt && exit_cause inside {[vm_exit_pkg::CAUSE_LIC_LINEAR:vm_exit_pkg::CAUSE_SLT_MISCONFIG]}
        |=> vectoring_valid_q) else $error("page or translation exit not valid");
    a_direct_invalid: assert property (
        exit_strobe && exit_cause inside {[vm_exit_pkg::CAUSE_DIRECT_EVENT:vm_exit_pkg::CAUSE_TRIPLE_FAULT]}
        |=> !vectoring_valid_q) else $error("direct exit marked valid");
    a_idle_invalid: assert property (exit_strobe && !delivery_active |=> !vectoring_valid_q)
        else $error("idle exit marked valid");
endmodule : vm_exit_sva
bind vm_exit_event_info_recorder vm_exit_sva i_sva (.pclk, .presetn, .psel, .penable, .pready_q, .exit_strobe,
    .exit_cause, .delivery_active, .delivery_via_idt, .task_checks_passed, .task_switch_source, .exit_recorded_q,
    .vectoring_valid_q);

/* dv/tb_top.sv */
// Self-checking bench for the exit event information recorder.
`timescale 1ns/1ps
module tb_top;
    logic                     pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic                     exit_strobe = 1'b0, delivery_active = 1'b0, pready_q, pslverr_q, last_err;
    logic                     exit_recorded_q, vectoring_valid_q;
    logic [3:0]               instr_length = 4'h0;
    logic [7:0]               ev_vector = 8'h00;
    logic [11:0]              paddr = 12'h000;
    logic [31:0]              pwdata = 32'h0, prdata_q, rd, ev_error_code = 32'h0000_1234;
    // Bits: 0 table path, 1 real-mode path, 2 v86, 3 checks passed, 4 sw instr, 5 has code, 6 external,
    // 7 injected, 8 trap-like, 9 priority write, 10 model write, 11 port string, 12 port output.
    logic [12:0]              flags = 13'h0009;
    // Bits: 1:0 address size, 4:2 segment, 6:5 task-switch source, 10:7 entry length.
    logic [10:0]              fields = 11'h000;
    vm_exit_pkg::exit_cause_t exit_cause = vm_exit_pkg::CAUSE_INSTR;
    vm_exit_pkg::ev_kind_t    ev_kind = vm_exit_pkg::KIND_EXCEPTION;
    int                       num_errors = 0, comparisons = 0;
    always #25 pclk = ~pclk;
    vm_exit_event_info_recorder i_vm_exit_event_info_recorder (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata_q, .pready_q, .pslverr_q,
        .exit_strobe, .exit_cause, .delivery_active, .delivery_via_idt(flags[0]), .delivery_via_rm_table(flags[1]),
        .v86_mode_flag(flags[2]), .task_checks_passed(flags[3]), .ev_kind, .ev_vector, .ev_sw_instr(flags[4]),
        .task_switch_source(vm_exit_pkg::ts_src_t'(fields[6:5])), .ev_has_error_code(flags[5]), .ev_error_code,
        .external_origin_flag(flags[6]), .ev_injected(flags[7]), .entry_instr_length(fields[10:7]), .instr_length,
        .instr_trap_like(flags[8]), .instr_task_priority_write(flags[9]), .instr_model_register_write(flags[10]),
        .instr_port_string(flags[11]), .instr_port_string_output(flags[12]), .instr_addr_size(fields[1:0]),
        .instr_segment(fields[4:2]), .exit_recorded_q, .vectoring_valid_q);
    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Read data and the error flag are taken at the very edge that samples pready high, then released.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 9; n++) begin
            @(posedge pclk);
            if (pready_q === 1'b1) break;
        end
        if (pready_q !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        rd = prdata_q;
        last_err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // The error code input is fixed, so a valid error flag always means 1234 with the external bit set.
    task automatic ex(input logic [3:0] c, input logic [2:0] k, input logic [7:0] v, input logic a,
                      input logic [3:0] n, input logic [31:0] ev, input logic [3:0] el, input logic [31:0] ei);
        @(posedge pclk);
        exit_cause <= vm_exit_pkg::exit_cause_t'(c);
        ev_kind <= vm_exit_pkg::ev_kind_t'(k);
        ev_vector <= v;
        delivery_active <= a;
        instr_length <= n;
        exit_strobe <= 1'b1;
        @(posedge pclk);
        exit_strobe <= 1'b0;
        flags <= 13'h0009;
        fields <= 11'h000;
        apb(1'b0, vm_exit_pkg::VEC_INFO_OFF, 32'h0);
        cmp(rd, ev);
        apb(1'b0, vm_exit_pkg::VEC_ERR_OFF, 32'h0);
        cmp(rd, ev[11] ? 32'h0000_1235 : 32'h0);
        apb(1'b0, vm_exit_pkg::INSTR_LEN_OFF, 32'h0);
        cmp(rd, {28'h0, el});
        apb(1'b0, vm_exit_pkg::INSTR_INFO_OFF, 32'h0);
        cmp(rd, ei);
    endtask : ex
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, vm_exit_pkg::VEC_INFO_OFF, 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            cmp(rd, {31'h0, i == 4});
        end
        apb(1'b0, 12'h01C, 32'h0);
        cmp({31'h0, last_err}, 32'h1);
        apb(1'b1, vm_exit_pkg::CTRL_OFF, 32'h1);
        flags <= 13'h0069;
        ex(4'h0, 3'h2, 8'h0E, 1'b1, 4'h0, 32'h8000_0B0E, 4'h0, 32'h0);
        flags <= 13'h0019;
        ex(4'h0, 3'h2, 8'h03, 1'b1, 4'h1, 32'h8000_0603, 4'h1, 32'h0);
        flags <= 13'h0019;
        ex(4'h0, 3'h2, 8'h06, 1'b1, 4'h5, 32'h8000_0306, 4'h0, 32'h0);
        ex(4'h4, 3'h1, 8'h77, 1'b1, 4'h0, 32'h8000_0202, 4'h0, 32'h0);
        ex(4'h5, 3'h0, 8'h41, 1'b1, 4'h0, 32'h8000_0041, 4'h0, 32'h0);
        flags <= 13'h0089;
        fields <= 11'h780;
        ex(4'h0, 3'h4, 8'h21, 1'b1, 4'h2, 32'h8000_0521, 4'hF, 32'h0);
        ex(4'h2, 3'h4, 8'h21, 1'b1, 4'h2, 32'h8000_0421, 4'h2, 32'h0);
        ex(4'h3, 3'h3, 8'h30, 1'b1, 4'h5, 32'h8000_0430, 4'h0, 32'h0);
        flags <= 13'h0001;
        fields <= 11'h060;
        ex(4'h1, 3'h3, 8'h30, 1'b1, 4'h3, 32'h0, 4'h0, 32'h0);
        fields <= 11'h060;
        ex(4'h1, 3'h3, 8'h30, 1'b1, 4'h3, 32'h8000_0430, 4'h3, 32'h0);
        for (int c = 8; c < 12; c++) ex(4'(c), 3'h2, 8'h08, 1'b1, 4'h4, 32'h0, 4'h0, 32'h0);
        flags <= 13'h000E;
        ex(4'h0, 3'h3, 8'h21, 1'b1, 4'h2, 32'h8000_0421, 4'h2, 32'h0);
        apb(1'b1, vm_exit_pkg::CTRL_OFF, 32'h0);
        flags <= 13'h000E;
        ex(4'h0, 3'h3, 8'h21, 1'b1, 4'h2, 32'h0, 4'h0, 32'h0);
        flags <= 13'h1809;
        fields <= 11'h00E;
        ex(4'h6, 3'h2, 8'h00, 1'b0, 4'h6, 32'h0, 4'h6, 32'h0001_8100);
        flags <= 13'h0809;
        fields <= 11'h015;
        ex(4'h6, 3'h2, 8'h00, 1'b0, 4'hF, 32'h0, 4'hF, 32'h0000_0080);
        flags <= 13'h0309;
        ex(4'h6, 3'h2, 8'h00, 1'b0, 4'h3, 32'h0, 4'h0, 32'h0);
        ex(4'h7, 3'h2, 8'h03, 1'b0, 4'h1, 32'h0, 4'h1, 32'h0);
        ex(4'h1, 3'h3, 8'h30, 1'b0, 4'h7, 32'h0, 4'h7, 32'h0);
        apb(1'b0, vm_exit_pkg::STATUS_OFF, 32'h0);
        cmp(rd, 32'h0015_0002);
        finish_test();
    end
endmodule : tb_top
